// >>> hdl/epwm_pkg.sv
/*
 * Package for the enhanced PWM block: register map, field positions,
 * reset values, output modes and the bus request carrier.
 * Assumes a classic Wishbone master with 32-bit data and byte addresses.
 */
package epwm_pkg;

    // Bus request carrier, all fields driven by the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } epwm_wb_req_t;

    // Output arrangement of the enhanced channel
    typedef enum logic [1:0] {
        EPWM_CFG_SINGLE   = 2'h0,
        EPWM_CFG_FULL_FWD = 2'h1,
        EPWM_CFG_HALF     = 2'h2,
        EPWM_CFG_FULL_REV = 2'h3
    } epwm_outcfg_t;

    // Register byte offsets
    localparam logic [7:0] EPWM_OFF_TSEL_CH123 = 8'h00;
    localparam logic [7:0] EPWM_OFF_TSEL_CH45  = 8'h04;
    localparam logic [7:0] EPWM_OFF_PERIOD_A   = 8'h08;
    localparam logic [7:0] EPWM_OFF_CONTROL_A  = 8'h14;
    localparam logic [7:0] EPWM_OFF_COUNT_A    = 8'h20;
    localparam logic [7:0] EPWM_OFF_CHAN_CTRL  = 8'h2c;
    localparam logic [7:0] EPWM_OFF_DUTY_HIGH  = 8'h30;
    localparam logic [7:0] EPWM_OFF_SHUTDOWN   = 8'h34;
    localparam logic [7:0] EPWM_OFF_AUX_CTRL   = 8'h38;
    localparam logic [7:0] EPWM_OFF_STEERING   = 8'h3c;
    localparam logic [7:0] EPWM_OFF_PIN_DIR    = 8'h40;
    localparam logic [7:0] EPWM_OFF_CH5_CTRL   = 8'h44;
    localparam logic [7:0] EPWM_OFF_CH5_DUTY   = 8'h48;
    localparam logic [7:0] EPWM_OFF_PORT_A     = 8'h4c;
    localparam logic [7:0] EPWM_OFF_STATUS     = 8'h50;
    localparam logic [7:0] EPWM_BASE_STRIDE    = 8'h04;

    // Implemented-bit masks; other bits read as zero
    localparam logic [7:0] EPWM_MASK_TSEL_CH123 = 8'hdb;
    localparam logic [7:0] EPWM_MASK_TSEL_CH45  = 8'h0f;
    localparam logic [7:0] EPWM_MASK_CONTROL    = 8'h7f;

    // Field positions
    localparam int EPWM_TSEL_CH1_LSB = 0;
    localparam int EPWM_TSEL_CH5_LSB = 2;
    localparam int EPWM_RUN_BIT      = 2;
    localparam int EPWM_SD_EVENT_BIT = 7;
    localparam int EPWM_RESTART_BIT  = 7;
    localparam int EPWM_SRQ_SEL_BIT  = 1;

    // Reset values
    localparam logic [7:0] EPWM_RST_PERIOD   = 8'hff;
    localparam logic [7:0] EPWM_RST_ZERO     = 8'h00;
    localparam logic [7:0] EPWM_RST_STEERING = 8'h01;
    localparam logic [4:0] EPWM_RST_PIN_DIR  = 5'h1f;

    // Prescale terminal counts for 1, 4 and 16
    localparam logic [3:0] EPWM_PRE_DIV1  = 4'h0;
    localparam logic [3:0] EPWM_PRE_DIV4  = 4'h3;
    localparam logic [3:0] EPWM_PRE_DIV16 = 4'hf;

endpackage : epwm_pkg

// >>> hdl/epwm_top.sv
/*
 * Enhanced PWM channel with three selectable 8-bit time bases, a simple
 * fifth channel sharing port A bit 4, auto-shutdown and dead-band.
 * Assumes a classic Wishbone master on clock, synchronous pin inputs and
 * an external pad that resolves each pin from its value and enable.
 */
`timescale 1ns/10ps

module epwm_top #(
    parameter int NUM_BASES = 3
) (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire epwm_pkg::epwm_wb_req_t wb_req,
    output logic                       wb_ack,
    output logic [31:0]                wb_dat_r,
    input  wire logic                  sleep,
    input  wire logic                  comparator1_out,
    input  wire logic                  comparator2_out,
    input  wire logic                  fault_input_n,
    input  wire logic                  set_reset_latch_out,
    output logic                       pwm_out_a_o,
    output logic                       pwm_out_a_oe,
    output logic                       pwm_out_b_o,
    output logic                       pwm_out_b_oe,
    output logic                       pwm_out_c_o,
    output logic                       pwm_out_c_oe,
    output logic                       pwm_out_d_o,
    output logic                       pwm_out_d_oe,
    output logic                       port_a_bit4_o,
    output logic                       port_a_bit4_oe
);

    // Prescale field to terminal count
    function automatic logic [3:0] pre_max(input logic [1:0] ps);
        unique case (ps)
            2'h0:    pre_max = epwm_pkg::EPWM_PRE_DIV1;
            2'h1:    pre_max = epwm_pkg::EPWM_PRE_DIV4;
            default: pre_max = epwm_pkg::EPWM_PRE_DIV16;
        endcase
    endfunction : pre_max

    // Timer select to base index; the reserved code falls back to base A
    function automatic logic [1:0] base_idx(input logic [1:0] tsel);
        base_idx = (tsel == 2'h3) ? 2'h0 : tsel;
    endfunction : base_idx

    logic [7:0]  tsel_ch123;
    logic [7:0]  tsel_ch45;
    logic [7:0]  period_value    [NUM_BASES];
    logic [7:0]  control_base    [NUM_BASES];
    logic [7:0]  time_base_count [NUM_BASES];
    logic [3:0]  pre_cnt         [NUM_BASES];
    logic [1:0]  sub_cnt         [NUM_BASES];
    logic [7:0]  channel_control;
    logic [7:0]  duty_high_part;
    logic [7:0]  shutdown_control_reg;
    logic [7:0]  pwm_aux_control;
    logic [7:0]  steering_control;
    logic [4:0]  pin_direction;
    logic [7:0]  ch5_control;
    logic [7:0]  ch5_duty_high;
    logic [1:0]  port_a_control;
    logic        pwm_lvl;
    logic        pwm_prev;
    logic        ch5_lvl;
    logic [6:0]  dead_cnt;

    logic        bus_req;
    logic        wr;
    logic [7:0]  wdat;
    logic [7:0]  next_rdat;
    logic [1:0]  ch1_base;
    logic [1:0]  ch5_base;
    logic [9:0]  ch1_fine;
    logic [9:0]  ch5_fine;
    logic [9:0]  ch1_duty;
    logic [9:0]  ch5_duty;
    logic        ch1_on;
    logic        ch5_on;
    logic        fault_now;
    logic        shut;
    logic        edge_dead;
    logic [3:0]  act;
    logic [3:0]  next_o;
    logic [3:0]  next_oe;

    assign bus_req = wb_req.cyc && wb_req.stb && !wb_ack;
    assign wr      = bus_req && wb_req.we && wb_req.sel[0];
    assign wdat    = wb_req.dat[7:0];

    // Bus answer: one wait state, ack stands for one cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack   <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack   <= bus_req;
            wb_dat_r <= (bus_req && !wb_req.we) ? {24'h00_0000, next_rdat}
                                                : 32'h0000_0000;
        end
    end

    // Configuration registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tsel_ch123       <= epwm_pkg::EPWM_RST_ZERO;
            tsel_ch45        <= epwm_pkg::EPWM_RST_ZERO;
            channel_control  <= epwm_pkg::EPWM_RST_ZERO;
            duty_high_part   <= epwm_pkg::EPWM_RST_ZERO;
            pwm_aux_control  <= epwm_pkg::EPWM_RST_ZERO;
            steering_control <= epwm_pkg::EPWM_RST_STEERING;
            pin_direction    <= epwm_pkg::EPWM_RST_PIN_DIR;
            ch5_control      <= epwm_pkg::EPWM_RST_ZERO;
            ch5_duty_high    <= epwm_pkg::EPWM_RST_ZERO;
            port_a_control   <= 2'h0;
        end else if (wr) begin
            unique case (wb_req.adr)
                epwm_pkg::EPWM_OFF_TSEL_CH123:
                    tsel_ch123 <= wdat & epwm_pkg::EPWM_MASK_TSEL_CH123;
                epwm_pkg::EPWM_OFF_TSEL_CH45:
                    tsel_ch45 <= wdat & epwm_pkg::EPWM_MASK_TSEL_CH45;
                epwm_pkg::EPWM_OFF_CHAN_CTRL: channel_control <= wdat;
                epwm_pkg::EPWM_OFF_DUTY_HIGH: duty_high_part  <= wdat;
                epwm_pkg::EPWM_OFF_AUX_CTRL:  pwm_aux_control <= wdat;
                epwm_pkg::EPWM_OFF_STEERING:  steering_control <= wdat;
                epwm_pkg::EPWM_OFF_PIN_DIR:   pin_direction   <= wdat[4:0];
                epwm_pkg::EPWM_OFF_CH5_CTRL:  ch5_control     <= wdat;
                epwm_pkg::EPWM_OFF_CH5_DUTY:  ch5_duty_high   <= wdat;
                epwm_pkg::EPWM_OFF_PORT_A:    port_a_control  <= wdat[1:0];
                default: ;
            endcase
        end
    end

    // Time bases: prescaler, two fine bits below an 8-bit count
    generate
        for (genvar i = 0; i < NUM_BASES; i++) begin : g_base
            logic [7:0] off_period;
            logic [7:0] off_control;
            logic [7:0] off_count;
            logic       run;
            logic       step;
            logic       wr_count;

            assign off_period  = epwm_pkg::EPWM_OFF_PERIOD_A
                               + 8'(i) * epwm_pkg::EPWM_BASE_STRIDE;
            assign off_control = epwm_pkg::EPWM_OFF_CONTROL_A
                               + 8'(i) * epwm_pkg::EPWM_BASE_STRIDE;
            assign off_count   = epwm_pkg::EPWM_OFF_COUNT_A
                               + 8'(i) * epwm_pkg::EPWM_BASE_STRIDE;
            // Sleep gates the whole base so the count is simply held
            assign run  = control_base[i][epwm_pkg::EPWM_RUN_BIT]
                          && !sleep;
            assign step = run && (pre_cnt[i]
                          == pre_max(control_base[i][1:0]));
            assign wr_count = wr && (wb_req.adr == off_count);

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    period_value[i] <= epwm_pkg::EPWM_RST_PERIOD;
                    control_base[i] <= epwm_pkg::EPWM_RST_ZERO;
                end else if (wr && wb_req.adr == off_period) begin
                    period_value[i] <= wdat;
                end else if (wr && wb_req.adr == off_control) begin
                    control_base[i] <= wdat & epwm_pkg::EPWM_MASK_CONTROL;
                end
            end

            // Clocked straight from the system clock
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    time_base_count[i] <= epwm_pkg::EPWM_RST_ZERO;
                    pre_cnt[i]         <= 4'h0;
                    sub_cnt[i]         <= 2'h0;
                end else if (wr_count) begin
                    // Writing the count also clears the prescaler
                    time_base_count[i] <= wdat;
                    pre_cnt[i]         <= 4'h0;
                    sub_cnt[i]         <= 2'h0;
                end else if (run) begin
                    pre_cnt[i] <= step ? 4'h0 : pre_cnt[i] + 4'h1;
                    if (step) begin
                        sub_cnt[i] <= sub_cnt[i] + 2'h1;
                        if (sub_cnt[i] == 2'h3) begin
                            if (time_base_count[i] == period_value[i])
                                time_base_count[i] <= 8'h00;
                            else
                                time_base_count[i] <=
                                    time_base_count[i] + 8'h01;
                        end
                    end
                end
            end
        end
    endgenerate

    // Channel time base and duty
    assign ch1_base = base_idx(tsel_ch123[epwm_pkg::EPWM_TSEL_CH1_LSB +: 2]);
    assign ch5_base = base_idx(tsel_ch45[epwm_pkg::EPWM_TSEL_CH5_LSB +: 2]);
    assign ch1_fine = {time_base_count[ch1_base], sub_cnt[ch1_base]};
    assign ch5_fine = {time_base_count[ch5_base], sub_cnt[ch5_base]};
    assign ch1_duty = {duty_high_part, channel_control[5:4]};
    assign ch5_duty = {ch5_duty_high, ch5_control[5:4]};
    assign ch1_on   = channel_control[3:2] == 2'h3;
    assign ch5_on   = ch5_control[3:2] == 2'h3;

    // Modulated levels; a width past the period holds the last level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwm_lvl <= 1'b0;
            ch5_lvl <= 1'b0;
        end else if (!sleep) begin
            if (duty_high_part <= period_value[ch1_base])
                pwm_lvl <= ch1_on && (ch1_fine < ch1_duty);
            if (ch5_duty_high <= period_value[ch5_base])
                ch5_lvl <= ch5_on && (ch5_fine < ch5_duty);
        end
    end

    // Dead-band timer restarts on each edge of the modulated level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwm_prev <= 1'b0;
            dead_cnt <= 7'h00;
        end else if (!sleep) begin
            pwm_prev <= pwm_lvl;
            if (pwm_lvl != pwm_prev)
                dead_cnt <= (pwm_aux_control[6:0] == 7'h00) ? 7'h00
                            : pwm_aux_control[6:0] - 7'h01;
            else if (dead_cnt != 7'h00)
                dead_cnt <= dead_cnt - 7'h01;
        end
    end

    assign edge_dead = (pwm_lvl != pwm_prev)
                       && (pwm_aux_control[6:0] != 7'h00);

    // Fault sources: bit 4 comparator 1, bit 5 comparator 2, bit 6 pin
    assign fault_now = (shutdown_control_reg[4] && comparator1_out)
                     || (shutdown_control_reg[5] && comparator2_out)
                     || (shutdown_control_reg[6] && !fault_input_n);
    assign shut = shutdown_control_reg[epwm_pkg::EPWM_SD_EVENT_BIT];

    // Shutdown control; a fault in the cycle of a clear keeps the event
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shutdown_control_reg <= epwm_pkg::EPWM_RST_ZERO;
        end else begin
            if (wr && wb_req.adr == epwm_pkg::EPWM_OFF_SHUTDOWN)
                shutdown_control_reg <= wdat;
            else if (!fault_now
                     && pwm_aux_control[epwm_pkg::EPWM_RESTART_BIT])
                shutdown_control_reg[epwm_pkg::EPWM_SD_EVENT_BIT]
                    <= 1'b0;
            if (fault_now)
                shutdown_control_reg[epwm_pkg::EPWM_SD_EVENT_BIT]
                    <= 1'b1;
        end
    end

    // Active levels per output before polarity
    always_comb begin
        act = 4'h0;
        unique case (epwm_pkg::epwm_outcfg_t'(channel_control[7:6]))
            epwm_pkg::EPWM_CFG_SINGLE:
                act = {4{pwm_lvl}} & steering_control[3:0];
            epwm_pkg::EPWM_CFG_FULL_FWD:
                act = {pwm_lvl, 1'b0, 1'b0, 1'b1};
            epwm_pkg::EPWM_CFG_HALF: begin
                act[0] = pwm_lvl && !edge_dead
                         && dead_cnt == 7'h00;
                act[1] = !pwm_lvl && !edge_dead && dead_cnt == 7'h00;
            end
            epwm_pkg::EPWM_CFG_FULL_REV:
                act = {1'b0, 1'b1, pwm_lvl, 1'b0};
        endcase
    end

    // Pin values and enables, bit 0 is output A
    always_comb begin
        next_o  = 4'h0;
        next_oe = ~pin_direction[3:0];
        if (shut) begin
            next_o  = {shutdown_control_reg[2], shutdown_control_reg[0],
                       shutdown_control_reg[2], shutdown_control_reg[0]};
            next_oe = next_oe & {!shutdown_control_reg[3],
                       !shutdown_control_reg[1], !shutdown_control_reg[3],
                       !shutdown_control_reg[1]};
        end else if (ch1_on) begin
            next_o = act ^ {channel_control[0], channel_control[1],
                            channel_control[0], channel_control[1]};
        end
    end

    // Registered pins; held in sleep so a driven level does not move
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwm_out_a_o  <= 1'b0;
            pwm_out_b_o  <= 1'b0;
            pwm_out_c_o  <= 1'b0;
            pwm_out_d_o  <= 1'b0;
            pwm_out_a_oe <= 1'b0;
            pwm_out_b_oe <= 1'b0;
            pwm_out_c_oe <= 1'b0;
            pwm_out_d_oe <= 1'b0;
        end else if (!sleep) begin
            pwm_out_a_o  <= next_o[0];
            pwm_out_b_o  <= next_o[1];
            pwm_out_c_o  <= next_o[2];
            pwm_out_d_o  <= next_o[3];
            pwm_out_a_oe <= next_oe[0];
            pwm_out_b_oe <= next_oe[1];
            pwm_out_c_oe <= next_oe[2];
            pwm_out_d_oe <= next_oe[3];
        end
    end

    // Shared port A bit 4 pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            port_a_bit4_o  <= 1'b0;
            port_a_bit4_oe <= 1'b0;
        end else if (!sleep) begin
            port_a_bit4_oe <= !pin_direction[4];
            if (port_a_control[epwm_pkg::EPWM_SRQ_SEL_BIT])
                port_a_bit4_o <= set_reset_latch_out;
            else if (ch5_on)
                port_a_bit4_o <= ch5_lvl;
            else
                port_a_bit4_o <= port_a_control[0];
        end
    end

    // Read-back; unmapped addresses answer zero
    always_comb begin
        next_rdat = 8'h00;
        unique case (wb_req.adr)
            epwm_pkg::EPWM_OFF_TSEL_CH123: next_rdat = tsel_ch123;
            epwm_pkg::EPWM_OFF_TSEL_CH45:  next_rdat = tsel_ch45;
            epwm_pkg::EPWM_OFF_CHAN_CTRL:  next_rdat = channel_control;
            epwm_pkg::EPWM_OFF_DUTY_HIGH:  next_rdat = duty_high_part;
            epwm_pkg::EPWM_OFF_SHUTDOWN:   next_rdat = shutdown_control_reg;
            epwm_pkg::EPWM_OFF_AUX_CTRL:   next_rdat = pwm_aux_control;
            epwm_pkg::EPWM_OFF_STEERING:   next_rdat = steering_control;
            epwm_pkg::EPWM_OFF_PIN_DIR:    next_rdat = {3'h0, pin_direction};
            epwm_pkg::EPWM_OFF_CH5_CTRL:   next_rdat = ch5_control;
            epwm_pkg::EPWM_OFF_CH5_DUTY:   next_rdat = ch5_duty_high;
            epwm_pkg::EPWM_OFF_PORT_A:     next_rdat = {6'h00, port_a_control};
            epwm_pkg::EPWM_OFF_STATUS:
                next_rdat = {4'h0, fault_now, ch5_lvl, pwm_lvl, shut};
            default: begin
                for (int k = 0; k < NUM_BASES; k++) begin
                    if (wb_req.adr == epwm_pkg::EPWM_OFF_PERIOD_A
                        + 8'(k) * epwm_pkg::EPWM_BASE_STRIDE)
                        next_rdat = period_value[k];
                    if (wb_req.adr == epwm_pkg::EPWM_OFF_CONTROL_A
                        + 8'(k) * epwm_pkg::EPWM_BASE_STRIDE)
                        next_rdat = control_base[k];
                    if (wb_req.adr == epwm_pkg::EPWM_OFF_COUNT_A
                        + 8'(k) * epwm_pkg::EPWM_BASE_STRIDE)
                        next_rdat = time_base_count[k];
                end
            end
        endcase
    end

endmodule : epwm_top

// >>> testbench/epwm_props.sv
/* Checker: bus handshake, read padding, sleep freeze, reset direction.
   Assumes the bind at the foot and the single clock domain. */
`timescale 1ns/10ps
module epwm_props (
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire epwm_pkg::epwm_wb_req_t wb_req,
    input wire logic                   wb_ack,
    input wire logic [31:0]            wb_dat_r,
    input wire logic                   sleep,
    input wire logic                   pwm_out_a_o,
    input wire logic                   pwm_out_a_oe,
    input wire logic                   pwm_out_b_o,
    input wire logic                   pwm_out_b_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ack_pulse_a: assert property (wb_ack |=> !wb_ack)
        else $error("ack held past one cycle");
    ack_late_a: assert property ($rose(wb_req.cyc && wb_req.stb) |=> wb_ack)
        else $error("ack not one cycle after request");
    ack_cause_a: assert property ($rose(wb_ack) |-> $past(wb_req.stb))
        else $error("ack without request");
    idle_zero_a: assert property (!wb_ack |-> wb_dat_r == 32'h0)
        else $error("read data outside ack");
    lane_zero_a: assert property (wb_ack |-> wb_dat_r[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    tsel_pad_a: assert property (wb_ack && $past(!wb_req.we &&
        wb_req.adr == epwm_pkg::EPWM_OFF_TSEL_CH123)
        |-> wb_dat_r[5] == 1'b0 && wb_dat_r[2] == 1'b0)
        else $error("timer select pad bits set");
    ctrl_pad_a: assert property (wb_ack && $past(!wb_req.we &&
        wb_req.adr == epwm_pkg::EPWM_OFF_CONTROL_A) |-> !wb_dat_r[7])
        else $error("control pad bit set");
    sleep_hold_a: assert property (sleep [*3] |-> $stable({
        pwm_out_a_o, pwm_out_a_oe, pwm_out_b_o, pwm_out_b_oe}))
        else $error("pin moved in sleep");
    reset_input_a: assert property ($rose(rst_n)
        |-> !pwm_out_a_oe && !pwm_out_b_oe)
        else $error("pin driven after reset");
endmodule : epwm_props

bind epwm_top epwm_props u_epwm_props (.clock(clock), .rst_n(rst_n),
    .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r), .sleep(sleep),
    .pwm_out_a_o(pwm_out_a_o), .pwm_out_a_oe(pwm_out_a_oe),
    .pwm_out_b_o(pwm_out_b_o), .pwm_out_b_oe(pwm_out_b_oe));

// >>> testbench/epwm_bridge.sv
/* Power bridge model: turns PWM pins into gate levels, owns fault pin.
   Assumes pull-downs on the gate inputs of the bridge. */
`timescale 1ns/10ps
module epwm_bridge (
    input  wire logic [3:0] pin_o,
    input  wire logic [3:0] pin_oe,
    input  wire logic       trip,
    output logic [3:0]      gate,
    output logic            fault_n
);
    // Released pin falls to the pull-down, never a stale level
    assign gate    = pin_o & pin_oe;
    assign fault_n = !trip;
endmodule : epwm_bridge

// >>> testbench/epwm_top_tb.sv
/* Testbench: registers, PWM timing, sleep, shutdown, port A4 priority.
   Assumes the checker binds itself and the bridge model beside it. */
`timescale 1ns/10ps
module epwm_top_tb;
    logic                   clock = 1'b0;
    logic                   rst_n = 1'b0;
    epwm_pkg::epwm_wb_req_t wb_req = '0;
    logic                   wb_ack;
    logic [31:0]            wb_dat_r;
    logic                   sleep = 1'b0;
    logic                   latch_q = 1'b0;
    logic                   trip = 1'b0;
    logic                   fault_n;
    logic                   a4_o;
    logic                   a4_oe;
    logic [3:0]             pin_o;
    logic [3:0]             pin_oe;
    logic [3:0]             gate;
    logic [31:0]            rd;
    int                     err_total = 0;
    int                     n_checks = 0;
    int                     ne;
    int                     nh;
    always #2 clock = ~clock;
    epwm_top u_epwm_top (.clock(clock), .rst_n(rst_n), .wb_req(wb_req),
        .wb_ack(wb_ack), .wb_dat_r(wb_dat_r), .sleep(sleep),
        .comparator1_out(1'b0), .comparator2_out(1'b0),
        .fault_input_n(fault_n), .set_reset_latch_out(latch_q),
        .pwm_out_a_o(pin_o[0]), .pwm_out_a_oe(pin_oe[0]),
        .pwm_out_b_o(pin_o[1]), .pwm_out_b_oe(pin_oe[1]),
        .pwm_out_c_o(pin_o[2]), .pwm_out_c_oe(pin_oe[2]),
        .pwm_out_d_o(pin_o[3]), .pwm_out_d_oe(pin_oe[3]),
        .port_a_bit4_o(a4_o), .port_a_bit4_oe(a4_oe));
    epwm_bridge u_epwm_bridge (.pin_o(pin_o), .pin_oe(pin_oe), .trip(trip),
        .gate(gate), .fault_n(fault_n));
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until ack is seen; a hang ends the run
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        wb_req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_dat_r;
        wb_req <= '0;
        if (n >= 50) begin
            err_total++;
            report_and_stop();
        end
        @(posedge clock);
    endtask : bus
    task automatic peek(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h0);
        chk(rd, exp);
    endtask : peek
    task automatic meas(input int cycles);
        logic prev;
        ne = 0;
        nh = 0;
        prev = gate[0];
        repeat (cycles) begin
            @(posedge clock);
            ne += int'(gate[0] && !prev);
            nh += int'(gate[0]);
            prev = gate[0];
        end
    endtask : meas
    task automatic t_regs;
        peek(epwm_pkg::EPWM_OFF_PERIOD_A, 32'hff);
        peek(epwm_pkg::EPWM_OFF_PIN_DIR, 32'h1f);
        peek(8'hfc, 32'h0);
        bus(1'b1, epwm_pkg::EPWM_OFF_TSEL_CH123, 8'hff);
        peek(epwm_pkg::EPWM_OFF_TSEL_CH123, 32'hdb);
        bus(1'b1, epwm_pkg::EPWM_OFF_CONTROL_A, 8'hff);
        peek(epwm_pkg::EPWM_OFF_CONTROL_A, 32'h7f);
    endtask : t_regs
    // Period 4 counts of 4 clocks; duty 9 quarter counts
    task automatic t_pwm;
        bus(1'b1, epwm_pkg::EPWM_OFF_TSEL_CH123, 8'h00);
        bus(1'b1, epwm_pkg::EPWM_OFF_PERIOD_A, 8'h03);
        bus(1'b1, epwm_pkg::EPWM_OFF_CHAN_CTRL, 8'h1c);
        bus(1'b1, epwm_pkg::EPWM_OFF_DUTY_HIGH, 8'h02);
        bus(1'b1, epwm_pkg::EPWM_OFF_CONTROL_A, 8'h04);
        bus(1'b1, epwm_pkg::EPWM_OFF_PIN_DIR, 8'h00);
        meas(16);
        meas(64);
        chk(ne, 32'd4);
        chk(nh, 32'd36);
        bus(1'b1, epwm_pkg::EPWM_OFF_CONTROL_A, 8'h06);
        meas(256);
        meas(256);
        chk(ne, 32'd1);
        chk(nh, 32'd144);
        bus(1'b1, epwm_pkg::EPWM_OFF_CONTROL_A, 8'h04);
        bus(1'b1, epwm_pkg::EPWM_OFF_CHAN_CTRL, 8'h0c);
        bus(1'b1, epwm_pkg::EPWM_OFF_DUTY_HIGH, 8'h00);
        bus(1'b1, epwm_pkg::EPWM_OFF_DUTY_HIGH, 8'h05);
        meas(64);
        chk(ne, 32'd0);
        chk(nh, 32'd0);
        bus(1'b1, epwm_pkg::EPWM_OFF_DUTY_HIGH, 8'h02);
        // Half bridge, two idle clocks after each edge
        bus(1'b1, epwm_pkg::EPWM_OFF_AUX_CTRL, 8'h02);
        bus(1'b1, epwm_pkg::EPWM_OFF_CHAN_CTRL, 8'h9c);
        meas(16);
        meas(64);
        chk(nh, 32'd28);
        bus(1'b1, epwm_pkg::EPWM_OFF_AUX_CTRL, 8'h00);
        bus(1'b1, epwm_pkg::EPWM_OFF_CHAN_CTRL, 8'h1c);
    endtask : t_pwm
    task automatic t_sleep;
        logic [31:0] held;
        sleep <= 1'b1;
        bus(1'b0, epwm_pkg::EPWM_OFF_COUNT_A, 8'h0);
        held = rd;
        repeat (6) @(posedge clock);
        peek(epwm_pkg::EPWM_OFF_COUNT_A, held);
        sleep <= 1'b0;
    endtask : t_sleep
    task automatic t_shut;
        bus(1'b1, epwm_pkg::EPWM_OFF_SHUTDOWN, 8'h89);
        repeat (4) @(posedge clock);
        chk({pin_oe[1], gate[0]}, 32'h1);
        bus(1'b1, epwm_pkg::EPWM_OFF_SHUTDOWN, 8'h88);
        repeat (4) @(posedge clock);
        chk(gate[0], 32'h0);
        bus(1'b1, epwm_pkg::EPWM_OFF_SHUTDOWN, 8'h08);
        meas(80);
        chk(ne >= 4, 32'h1);
        bus(1'b1, epwm_pkg::EPWM_OFF_AUX_CTRL, 8'h80);
        bus(1'b1, epwm_pkg::EPWM_OFF_SHUTDOWN, 8'h88);
        repeat (8) @(posedge clock);
        peek(epwm_pkg::EPWM_OFF_SHUTDOWN, 32'h08);
        bus(1'b1, epwm_pkg::EPWM_OFF_SHUTDOWN, 8'h40);
        trip <= 1'b1;
        repeat (4) @(posedge clock);
        peek(epwm_pkg::EPWM_OFF_SHUTDOWN, 32'hc0);
        trip <= 1'b0;
        repeat (4) @(posedge clock);
        peek(epwm_pkg::EPWM_OFF_SHUTDOWN, 32'h40);
        bus(1'b1, epwm_pkg::EPWM_OFF_AUX_CTRL, 8'h00);
        trip <= 1'b1;
        repeat (4) @(posedge clock);
        trip <= 1'b0;
        repeat (4) @(posedge clock);
        peek(epwm_pkg::EPWM_OFF_SHUTDOWN, 32'hc0);
        bus(1'b1, epwm_pkg::EPWM_OFF_SHUTDOWN, 8'h00);
    endtask : t_shut
    task automatic t_a4;
        bus(1'b1, epwm_pkg::EPWM_OFF_PORT_A, 8'h01);
        bus(1'b1, epwm_pkg::EPWM_OFF_CH5_CTRL, 8'h0c);
        repeat (8) @(posedge clock);
        chk({a4_oe, a4_o}, 32'h2);
        latch_q <= 1'b1;
        bus(1'b1, epwm_pkg::EPWM_OFF_PORT_A, 8'h02);
        repeat (4) @(posedge clock);
        chk({a4_oe, a4_o}, 32'h3);
    endtask : t_a4
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_regs();
        t_pwm();
        t_sleep();
        t_shut();
        t_a4();
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        chk({pin_oe, a4_oe}, 32'h0);
        rst_n <= 1'b1;
        @(posedge clock);
        peek(epwm_pkg::EPWM_OFF_PORT_A, 32'h0);
        report_and_stop();
    end
endmodule : epwm_top_tb
